//--- ir_frame_cfg.svh
// Constants for the infrared frame controller: offsets, fields, timing
`ifndef IR_FRAME_CFG_SVH
`define IR_FRAME_CFG_SVH
// Register addresses
`define A_DATA      4'h0
`define A_IEN       4'h1
`define A_EVT       4'h2
`define A_LSTAT     4'h3
`define A_LCTL1     4'h4
`define A_LCTL2     4'h5
`define A_MODE      4'h6
`define A_DMA       4'h7
`define A_THR       4'h8
`define A_TFL_LO    4'h9
`define A_TFL_HI    4'ha
`define A_MDS_LO    4'hb
`define A_RST_HI    4'hc
`define A_TEST      4'hf
// Field positions
`define B_TXEN      0
`define B_RXEN      1
`define B_FCLR      4
`define B_CVIEW     7
`define B_DMAEN     0
`define E_TXE       7
`define E_TOUT      5
`define E_EOF       4
`define E_MLE       3
`define E_CRC       2
`define E_OVR       1
// Reset value of every control register
`define REG_RST     8'h00
// Framing bytes and CRC constants
`define FR_BOF      8'hc0
`define FR_EOF      8'hc1
`define FR_ESC      8'h7d
`define FR_XOR      8'h20
`define FR_FLAG     8'h7e
`define CRC_INIT    16'hffff
`define CRC_GOOD    16'hf0b8
// Timing
`define CLK_HZ      20000000
`define CLK_NS      50
`define TOUT_FAST_NS 69500
`define TOUT_FAST_CYC ((`TOUT_FAST_NS + `CLK_NS - 1) / `CLK_NS)
`define TOUT_BITS   (4 * 8)
`define BIT_CYC(b)  ((`CLK_HZ + (b) - 1) / (b))
`endif

//--- ir_frame_pkg.sv
// Types shared by the infrared frame controller
`default_nettype none
package ir_frame_pkg;
	typedef enum logic [1:0] {M_SIR, M_EXSIR, M_MIR, M_FIR} mode_e;
	typedef enum logic [2:0] {T_IDLE, T_BOF, T_DATA, T_ESC, T_CRC1,
		T_CRC2, T_EOF} tx_state_e;
endpackage : ir_frame_pkg
`default_nettype wire

//--- ir_byte_fifo.sv
// Byte FIFO of 32 entries with fill count
`default_nettype none
module ir_byte_fifo #(
	parameter int W = 8
) (
	input  wire logic         ref_clk,  // System clock
	input  wire logic         rst_n,    // Async reset
	input  wire logic         clr,      // Flush contents
	input  wire logic         push,     // Write one entry
	input  wire logic [W-1:0] wdata,    // Entry written
	input  wire logic         pop,      // Drop head entry
	output logic [W-1:0]      rdata,    // Head entry
	output logic [5:0]        count,    // Entries held
	output logic              full,     // No room
	output logic              empty     // Nothing held
);
	logic [W-1:0] mem [32];   // Storage array
	logic [4:0]   wrPtr_r;    // Write pointer
	logic [4:0]   rdPtr_r;    // Read pointer
	logic [5:0]   count_r;    // Fill level
	logic         doPush;     // Accepted push
	logic         doPop;      // Accepted pop

	assign full   = (count_r == 6'h20);
	assign empty  = (count_r == 6'h00);
	assign count  = count_r;
	assign rdata  = mem[rdPtr_r];
	assign doPush = push && !full;
	assign doPop  = pop && !empty;

	// Storage write
	always_ff @(posedge ref_clk)
	begin
		if (doPush)
			mem[wrPtr_r] <= wdata;
	end

	// Pointers and level
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrPtr_r <= 5'h00;
			rdPtr_r <= 5'h00;
			count_r <= 6'h00;
		end
		else if (clr)
		begin
			wrPtr_r <= 5'h00;
			rdPtr_r <= 5'h00;
			count_r <= 6'h00;
		end
		else
		begin
			if (doPush)
				wrPtr_r <= wrPtr_r + 5'h01;
			if (doPop)
				rdPtr_r <= rdPtr_r + 5'h01;
			if (doPush && !doPop)
				count_r <= count_r + 6'h01;
			else if (doPop && !doPush)
				count_r <= count_r - 6'h01;
		end
	end
endmodule : ir_byte_fifo
`default_nettype wire

//--- infrared_frame_controller.sv
// Infrared frame controller: host registers, framing, DMA, time-out
// Function
// RULE1: four modes: plain, extended slow, medium, fast
// RULE2: plain slow mode passes raw bytes only
// RULE3: extended slow frames, escapes, CRC, allows DMA
// RULE4: medium mode delimits frames and checks CRC
// RULE5: fast mode delimits frames and checks CRC
// RULE6: transmit or receive enable bit picks direction
// RULE7: both enables clear means idle
// RULE8: registers and transmit queue writable while idle
// RULE9: both enables set means receive
// RULE10: single and demand DMA only, no block
// RULE11: software sets frame length and DMA count
// RULE12: receive request at threshold or time-out
// RULE13: receive request drops when queue empties
// RULE14: send request below threshold, drops full/empty
// RULE15: time-out raises interrupt or DMA request
// RULE16: fast modes time out after 69.5 us
// RULE17: slow modes time out after 32 bits
// RULE18: 4-bit address selects registers 0h..Ch
// RULE19: 9h/Ah write length, read live count
// RULE20: Bh/Ch write max size, read length stack (code: high byte written at 0h with view set, Ch ignores writes)
// RULE21: view select picks programmed or live values
// RULE22: time-out restarts on write or read
`default_nettype none
`include "ir_frame_cfg.svh"
module infrared_frame_controller #(
	parameter int BIT_CYC_2400 = `BIT_CYC(2400)  // Bit period at 2400 bps
) (
	input  wire logic                ref_clk,   // 20 MHz clock
	input  wire logic                rst_n,     // Async reset
	input  wire logic                csN,       // Chip select
	input  wire logic                rdN,       // Read strobe
	input  wire logic                wrN,       // Write strobe
	input  wire logic [3:0]          addr,      // Register address
	input  wire logic [7:0]          dataIn,    // Host write data
	output logic      [7:0]          dataOut,   // Host read data
	output logic                     dataOe,    // Read data drive
	output logic                     dreq,      // DMA request
	input  wire logic                dackN,     // DMA acknowledge
	input  wire logic                tcN,       // DMA terminal count
	output logic                     intReq,    // Interrupt request
	output ir_frame_pkg::mode_e      linkMode,  // Mode to line coder
	output logic                     sendMode,  // Link sending
	output logic                     recvMode,  // Link receiving
	output logic      [7:0]          txByte,    // Byte to line coder
	output logic                     txValid,   // Byte offered
	input  wire logic                txReady,   // Coder takes byte
	input  wire logic [7:0]          rxByte,    // Byte from line coder
	input  wire logic                rxValid,   // Byte present
	input  wire logic                rxFlag     // Delimiter seen
);
	import ir_frame_pkg::*;

	// Control registers
	logic [7:0]  intEnable_r;   // Interrupt enable
	logic [7:0]  events_r;      // Sticky events
	logic [7:0]  linkCtl1_r;    // Link control one
	logic [7:0]  linkCtl2_r;    // Count view control
	logic [7:0]  modeRate_r;    // Mode and rate
	logic [7:0]  dmaSetup_r;    // DMA setup
	logic [7:0]  thresh_r;      // Queue thresholds
	logic [11:0] txFrameLen_r;  // Transmit frame length
	logic [15:0] maxSize_r;     // Max receive data size
	logic [7:0]  test_r;        // Factory check scratch
	logic [11:0] txLiveCnt_r;   // Bytes sent this frame
	logic [15:0] rxLenStack_r;  // Last received length
	logic [15:0] rxLen_r;       // Running receive length
	// Bus strobes
	logic        wrNPrev_r;     // Write strobe history
	logic        rdNPrev_r;     // Read strobe history
	logic        wrStart;       // Write strobe fell
	logic        rdStart;       // Read strobe fell
	logic        hostWr;        // Register write
	logic        hostRd;        // Register read
	logic        dmaWr;         // DMA write to queue
	logic        dmaRd;         // DMA read from queue
	logic        countView;     // Show live counts
	logic        fifoClr;       // Flush both queues
	logic [7:0]  readVal;       // Read mux result
	// Queues
	logic        txPush;
	logic        txPop;
	logic [8:0]  txHead;        // Head with last mark
	logic [5:0]  txCount;
	logic        txFull;
	logic        txEmpty;
	logic        rxPush;
	logic        rxPop;
	logic [7:0]  rxPushByte;
	logic [7:0]  rxHead;
	logic [5:0]  rxCount;
	logic        rxFull;
	logic        rxEmpty;
	// Framing
	mode_e       mode;
	tx_state_e   txState_r;
	logic [15:0] txCrc_r;       // Transmit CRC
	logic [15:0] rxCrc_r;       // Receive CRC
	logic        rxEsc_r;       // Next byte escaped
	logic        rxInFrame_r;   // Inside a frame
	logic        linkFree;      // Output slot open
	logic        needEsc;       // Head needs escaping
	logic        lastByte;      // Head ends frame
	logic        txEmptyEvt;    // Frame closed, queue empty
	logic        rxEofEvt;      // Frame end received
	logic        rxData;        // Payload byte received
	// Time-out
	logic [13:0] bitCyc;        // Cycles per bit
	logic [13:0] bitDiv_r;      // Bit divider
	logic [10:0] toutCnt_r;     // Time-out progress
	logic [10:0] toutLimit;
	logic        toutTick;
	logic        toutFlag_r;    // Time-out standing
	logic        toutRestart;

	// CRC-16 over one byte, reflected
	function automatic logic [15:0] crcByte(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ 16'h8408) : (r >> 1);
		return r;
	endfunction : crcByte

	// Mode decode and direction
	assign mode     = mode_e'(modeRate_r[1:0]);  // see RULE1
	assign countView = linkCtl2_r[`B_CVIEW];
	// Receive wins when both enables set; none set is idle
	assign recvMode = linkCtl1_r[`B_RXEN];  // see RULE6, RULE9
	assign sendMode = linkCtl1_r[`B_TXEN] && !linkCtl1_r[`B_RXEN];  // see RULE7
	assign linkMode = mode;

	// Strobe edge detect
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrNPrev_r <= 1'b1;
			rdNPrev_r <= 1'b1;
		end
		else
		begin
			wrNPrev_r <= wrN;
			rdNPrev_r <= rdN;
		end
	end

	assign wrStart = !wrN && wrNPrev_r;
	assign rdStart = !rdN && rdNPrev_r;
	assign hostWr  = wrStart && !csN;  // see RULE18
	assign hostRd  = rdStart && !csN;
	// DMA strobes hit the data port only, one byte per strobe
	assign dmaWr   = wrStart && !dackN && dmaSetup_r[`B_DMAEN];  // see RULE10
	assign dmaRd   = rdStart && !dackN && dmaSetup_r[`B_DMAEN];
	assign fifoClr = hostWr && addr == `A_LCTL1 && dataIn[`B_FCLR];

	// Register writes, accepted in every direction state
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			intEnable_r  <= `REG_RST;
			linkCtl1_r   <= `REG_RST;
			linkCtl2_r   <= `REG_RST;
			modeRate_r   <= `REG_RST;
			dmaSetup_r   <= `REG_RST;
			thresh_r     <= `REG_RST;
			txFrameLen_r <= 12'h000;
			maxSize_r    <= 16'h0000;
			test_r       <= `REG_RST;
		end
		else if (hostWr)  // see RULE8
		begin
			if (addr == `A_DATA && countView)
				maxSize_r[15:8] <= dataIn;
			else if (addr == `A_IEN)
				intEnable_r <= dataIn;
			else if (addr == `A_LCTL1)
				// Flush bit acts once, not stored
				linkCtl1_r <= dataIn & ~(8'h01 << `B_FCLR);  // see RULE6
			else if (addr == `A_LCTL2)
				linkCtl2_r <= dataIn;
			else if (addr == `A_MODE)
				modeRate_r <= dataIn;
			else if (addr == `A_DMA)
				dmaSetup_r <= dataIn;
			else if (addr == `A_THR)
				thresh_r <= dataIn;
			else if (addr == `A_TFL_LO)
				txFrameLen_r[7:0] <= dataIn;  // see RULE19, RULE11
			else if (addr == `A_TFL_HI)
				txFrameLen_r[11:8] <= dataIn[3:0];
			else if (addr == `A_MDS_LO)
				maxSize_r[7:0] <= dataIn;  // see RULE20
			else if (addr == `A_TEST)
				test_r <= dataIn;
		end
	end

	// Read mux
	always_comb
	begin
		readVal = 8'h00;
		if (addr == `A_DATA)
			readVal = rxHead;
		else if (addr == `A_IEN)
			readVal = intEnable_r;
		else if (addr == `A_EVT)
			readVal = events_r;
		else if (addr == `A_LSTAT)
			readVal = {rxCount, rxInFrame_r, toutFlag_r};
		else if (addr == `A_LCTL1)
			readVal = linkCtl1_r;
		else if (addr == `A_LCTL2)
			readVal = linkCtl2_r;
		else if (addr == `A_MODE)
			readVal = modeRate_r;
		else if (addr == `A_DMA)
			readVal = dmaSetup_r;
		else if (addr == `A_THR)
			readVal = thresh_r;
		else if (addr == `A_TFL_LO)  // see RULE19, RULE21
			readVal = countView ? txLiveCnt_r[7:0] : txFrameLen_r[7:0];
		else if (addr == `A_TFL_HI)
			readVal = countView ? {4'h0, txLiveCnt_r[11:8]}
				: {4'h0, txFrameLen_r[11:8]};
		else if (addr == `A_MDS_LO)  // see RULE20, RULE21
			readVal = countView ? rxLenStack_r[7:0] : maxSize_r[7:0];
		else if (addr == `A_RST_HI)
			readVal = rxLenStack_r[15:8];
		else if (addr == `A_TEST)
			readVal = test_r;
	end

	// Read data register and drive
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dataOut <= 8'h00;
			dataOe  <= 1'b0;
		end
		else
		begin
			if (dmaRd)
				dataOut <= rxHead;
			else if (hostRd)
				dataOut <= readVal;
			dataOe <= !rdN && (!csN || !dackN);
		end
	end

	// Queues
	assign txPush = (hostWr && addr == `A_DATA && !countView) || dmaWr;
	assign rxPop  = (hostRd && addr == `A_DATA) || dmaRd;

	ir_byte_fifo #(.W(9)) txQueue (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clr     (fifoClr),
		.push    (txPush),
		.wdata   ({dmaWr && !tcN, dataIn}),
		.pop     (txPop),
		.rdata   (txHead),
		.count   (txCount),
		.full    (txFull),
		.empty   (txEmpty)
	);

	ir_byte_fifo #(.W(8)) rxQueue (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clr     (fifoClr),
		.push    (rxPush),
		.wdata   (rxPushByte),
		.pop     (rxPop),
		.rdata   (rxHead),
		.count   (rxCount),
		.full    (rxFull),
		.empty   (rxEmpty)
	);

	// Transmit take decisions
	assign linkFree = !txValid || txReady;
	assign needEsc  = mode == M_EXSIR && (txHead[7:0] == `FR_BOF
		|| txHead[7:0] == `FR_EOF || txHead[7:0] == `FR_ESC);  // see RULE3
	// Frame ends on terminal count mark or programmed length
	assign lastByte = txHead[8] || (txFrameLen_r != 12'h000
		&& txLiveCnt_r + 12'h001 == txFrameLen_r);
	always_comb
	begin
		txPop = 1'b0;
		if (sendMode && linkFree && !txEmpty)
		begin
			if (mode == M_SIR && txState_r == T_IDLE)
				txPop = 1'b1;  // see RULE2
			else if (txState_r == T_DATA && !needEsc)
				txPop = 1'b1;
			else if (txState_r == T_ESC)
				txPop = 1'b1;
		end
	end
	assign txEmptyEvt = sendMode && linkFree && txEmpty
		&& (txState_r == T_EOF || (mode == M_SIR && txState_r == T_IDLE
		&& txValid && txReady));

	// Transmit framer
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txState_r   <= T_IDLE;
			txByte      <= 8'h00;
			txValid     <= 1'b0;
			txCrc_r     <= `CRC_INIT;
			txLiveCnt_r <= 12'h000;
		end
		else if (!sendMode)
		begin
			txState_r <= T_IDLE;
			if (txReady)
				txValid <= 1'b0;
		end
		else if (linkFree)
		begin
			txValid <= 1'b0;
			case (txState_r)
				T_IDLE:
				begin
					if (!txEmpty && mode == M_SIR)
					begin
						txByte  <= txHead[7:0];
						txValid <= 1'b1;
					end
					else if (!txEmpty)
					begin
						txState_r   <= T_BOF;
						txCrc_r     <= `CRC_INIT;
						txLiveCnt_r <= 12'h000;
					end
				end
				T_BOF:
				begin
					// Medium and fast use flag delimiters
					txByte    <= (mode == M_EXSIR) ? `FR_BOF : `FR_FLAG;  // see RULE4, RULE5
					txValid   <= 1'b1;
					txState_r <= T_DATA;
				end
				T_DATA, T_ESC:
				begin
					if (!txEmpty && txState_r == T_DATA && needEsc)
					begin
						txByte    <= `FR_ESC;
						txValid   <= 1'b1;
						txState_r <= T_ESC;
					end
					else if (!txEmpty)
					begin
						txByte      <= (txState_r == T_ESC)
							? (txHead[7:0] ^ `FR_XOR) : txHead[7:0];
						txValid     <= 1'b1;
						txCrc_r     <= crcByte(txCrc_r, txHead[7:0]);
						txLiveCnt_r <= txLiveCnt_r + 12'h001;
						txState_r   <= lastByte ? T_CRC1 : T_DATA;
					end
				end
				T_CRC1:
				begin
					txByte    <= ~txCrc_r[7:0];
					txValid   <= 1'b1;
					txState_r <= T_CRC2;
				end
				T_CRC2:
				begin
					txByte    <= ~txCrc_r[15:8];
					txValid   <= 1'b1;
					txState_r <= T_EOF;
				end
				T_EOF:
				begin
					txByte    <= (mode == M_EXSIR) ? `FR_EOF : `FR_FLAG;
					txValid   <= 1'b1;
					txState_r <= T_IDLE;
				end
				default:
					txState_r <= T_IDLE;
			endcase
		end
	end

	// Receive payload classification
	assign rxData = recvMode && rxValid && (mode == M_SIR
		|| (mode == M_EXSIR && rxInFrame_r && !(rxByte == `FR_BOF
		|| rxByte == `FR_EOF || rxByte == `FR_ESC) && !rxFlag)
		|| (mode != M_EXSIR && rxInFrame_r && !rxFlag));  // see RULE2, RULE3
	assign rxPushByte = rxEsc_r ? (rxByte ^ `FR_XOR) : rxByte;
	assign rxPush = rxData;
	assign rxEofEvt = recvMode && rxValid && rxInFrame_r && mode != M_SIR
		&& ((mode == M_EXSIR && rxByte == `FR_EOF)
		|| (mode != M_EXSIR && rxFlag && rxLen_r != 16'h0000));  // see RULE4, RULE5

	// Receive deframer and length stack
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxInFrame_r  <= 1'b0;
			rxEsc_r      <= 1'b0;
			rxCrc_r      <= `CRC_INIT;
			rxLen_r      <= 16'h0000;
			rxLenStack_r <= 16'h0000;
		end
		else if (!recvMode || mode == M_SIR)
		begin
			rxInFrame_r <= 1'b0;
			rxEsc_r     <= 1'b0;
		end
		else if (rxEofEvt)
		begin
			rxInFrame_r  <= 1'b0;
			rxLenStack_r <= rxLen_r;
		end
		else if (rxValid && ((mode == M_EXSIR && rxByte == `FR_BOF)
			|| (mode != M_EXSIR && rxFlag)))
		begin
			rxInFrame_r <= 1'b1;
			rxEsc_r     <= 1'b0;
			rxCrc_r     <= `CRC_INIT;
			rxLen_r     <= 16'h0000;
		end
		else if (rxValid && rxInFrame_r && mode == M_EXSIR
			&& rxByte == `FR_ESC)
			rxEsc_r <= 1'b1;
		else if (rxData)
		begin
			rxEsc_r <= 1'b0;
			rxCrc_r <= crcByte(rxCrc_r, rxPushByte);
			rxLen_r <= rxLen_r + 16'h0001;
		end
	end

	// Time-out base: 32 bit periods slow, fixed delay fast
	always_comb
	begin
		bitCyc = 14'(BIT_CYC_2400);
		if (modeRate_r[7:5] == 3'h1)
			bitCyc = 14'(`BIT_CYC(9600));
		else if (modeRate_r[7:5] == 3'h2)
			bitCyc = 14'(`BIT_CYC(19200));
		else if (modeRate_r[7:5] == 3'h3)
			bitCyc = 14'(`BIT_CYC(38400));
		else if (modeRate_r[7:5] == 3'h4)
			bitCyc = 14'(`BIT_CYC(57600));
		else if (modeRate_r[7:5] == 3'h5)
			bitCyc = 14'(`BIT_CYC(115200));
	end
	assign toutLimit = (mode == M_MIR || mode == M_FIR)
		? 11'(`TOUT_FAST_CYC) : 11'(`TOUT_BITS);  // see RULE16, RULE17
	assign toutTick  = (mode == M_MIR || mode == M_FIR)
		|| bitDiv_r == bitCyc - 14'h0001;
	assign toutRestart = rxPush || rxPop;  // see RULE22

	// Time-out counter
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bitDiv_r   <= 14'h0000;
			toutCnt_r  <= 11'h000;
			toutFlag_r <= 1'b0;
		end
		else if (toutRestart || rxEmpty || !recvMode)  // see RULE22
		begin
			bitDiv_r   <= 14'h0000;
			toutCnt_r  <= 11'h000;
			toutFlag_r <= 1'b0;
		end
		else if (!toutFlag_r)
		begin
			bitDiv_r <= toutTick ? 14'h0000 : bitDiv_r + 14'h0001;
			if (toutTick)
				toutCnt_r <= toutCnt_r + 11'h001;
			if (toutTick && toutCnt_r == toutLimit - 11'h001)
				toutFlag_r <= 1'b1;  // see RULE16, RULE17
		end
	end

	// Sticky events, cleared by reading; a new event wins
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			events_r <= `REG_RST;
		else
		begin
			if (hostRd && addr == `A_EVT)
				events_r <= 8'h00;
			if (txEmptyEvt)
				events_r[`E_TXE] <= 1'b1;
			// Time-out routed to interrupt when DMA is off
			if (toutFlag_r && !dmaSetup_r[`B_DMAEN])
				events_r[`E_TOUT] <= 1'b1;  // see RULE15
			if (rxEofEvt)
				events_r[`E_EOF] <= 1'b1;
			if (rxEofEvt && rxCrc_r != `CRC_GOOD)
				events_r[`E_CRC] <= 1'b1;  // see RULE3
			if (rxData && rxLen_r >= maxSize_r)
				events_r[`E_MLE] <= 1'b1;
			if (rxPush && rxFull)
				events_r[`E_OVR] <= 1'b1;
		end
	end

	// Interrupt and DMA request
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			intReq <= 1'b0;
			dreq   <= 1'b0;
		end
		else
		begin
			intReq <= |(events_r & intEnable_r);
			if (!dmaSetup_r[`B_DMAEN] || (!recvMode && !sendMode))
				dreq <= 1'b0;
			else if (recvMode)
			begin
				if (rxEmpty || (rxPop && rxCount == 6'h01))
					dreq <= 1'b0;  // see RULE13
				else if (rxCount >= {2'b00, thresh_r[7:4]} || toutFlag_r)
					dreq <= 1'b1;  // see RULE12, RULE15
			end
			else
			begin
				if (txFull || txEmptyEvt)
					dreq <= 1'b0;  // see RULE14
				else if (txCount < {2'b00, thresh_r[3:0]})
					dreq <= 1'b1;
			end
		end
	end
endmodule : infrared_frame_controller
`default_nettype wire

//--- ir_frame_assertions.sv
// Port-level checker for the infrared frame controller
`default_nettype none
module ir_frame_assertions
	import ir_frame_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       csN,
	input wire logic       rdN,
	input wire logic       wrN,
	input wire logic [3:0] addr,
	input wire logic [7:0] dataIn,
	input wire logic [7:0] dataOut,
	input wire logic       dataOe,
	input wire logic       dreq,
	input wire logic       dackN,
	input wire logic       txValid,
	input wire logic       txReady,
	input wire logic [7:0] txByte,
	input wire logic       sendMode,
	input wire logic       recvMode,
	input wire mode_e      linkMode
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_dir_excl: assert property (sendMode |-> !recvMode)
		else $error("send and receive both active");
	a_dir_write: assert property ($fell(wrN) && !csN && dackN &&
		addr == 4'h4 |=> recvMode == $past(dataIn[1]) &&
		sendMode == ($past(dataIn[0]) && !$past(dataIn[1])))
		else $error("direction not taken from control write");
	a_idle_quiet: assert property ((!sendMode && !recvMode)[*2]
		|-> !dreq) else $error("request raised while idle");
	a_tx_idle: assert property (!sendMode && !txValid
		|=> !txValid) else $error("byte offered while not sending");
	a_tx_hold: assert property (txValid && !txReady
		|=> txValid && $stable(txByte)) else $error("offered byte dropped");
	a_oe_follow: assert property (dataOe ==
		(!$past(rdN) && (!$past(csN) || !$past(dackN))))
		else $error("drive enable wrong");
	a_unmapped_rd: assert property ($fell(rdN) && !csN && dackN &&
		addr == 4'hd |=> dataOut == 8'h00)
		else $error("unmapped read not zero");
	a_mode_write: assert property ($fell(wrN) && !csN && dackN &&
		addr == 4'h6 |=> linkMode == $past(dataIn[1:0]))
		else $error("mode field not taken");
	c_rx_dma: cover property (dreq && recvMode);
	c_tx_byte: cover property (txValid && txReady);
	c_dma_rd: cover property ($fell(rdN) && !dackN);
endmodule : ir_frame_assertions
`default_nettype wire

//--- ir_coder_model.sv
// Line coder stand-in: takes transmit bytes with stalls, offers receive bytes
`default_nettype none
module ir_coder_model (
	input  wire logic       ref_clk,  // System clock
	input  wire logic       txValid,  // Byte offered
	input  wire logic [7:0] txByte,   // Offered byte
	output logic            txReady,  // Byte taken
	output logic      [7:0] rxByte,   // Received byte
	output logic            rxValid,  // Byte strobe
	output logic            rxFlag    // Delimiter strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] txSeen[$];     // Bytes taken, in order
	logic [2:0] slot = 3'h0;   // Stall pattern
	initial
	begin
		txReady = 1'b0;
		rxByte = 8'h00;
		rxValid = 1'b0;
		rxFlag = 1'b0;
	end
	// Accept one byte per handshake, stalling one slot in four
	always @(posedge ref_clk)
	begin
		slot <= slot + 3'h1;
		txReady <= slot[1:0] != 2'h0;
		if (txValid && txReady)
			txSeen.push_back(txByte);
	end
	// One-cycle byte strobe; line shows the inverse afterwards
	task automatic put(input logic [7:0] b, input logic f);
		@(posedge ref_clk);
		rxByte <= b;
		rxValid <= 1'b1;
		rxFlag <= f;
		@(posedge ref_clk);
		rxByte <= ~b;
		rxValid <= 1'b0;
		rxFlag <= 1'b0;
	endtask : put
endmodule : ir_coder_model
`default_nettype wire

//--- test_infrared_frame_controller.sv
// Self-checking bench for the infrared frame controller
`default_nettype none
`include "ir_frame_cfg.svh"
module test_infrared_frame_controller;
	timeunit 1ns;
	timeprecision 1ps;
	import ir_frame_pkg::*;
	logic ref_clk, rst_n, csN, rdN, wrN, dackN, tcN;
	logic [3:0] addr;
	logic [7:0] dataIn, dataOut, txByte, rxByte, q, v;
	logic dataOe, dreq, intReq, sendMode, recvMode, txValid, txReady;
	logic rxValid, rxFlag;
	mode_e linkMode;
	int err_count = 0, cmp_count = 0, cyc = 0, i, n;
	int seed = 32'h75a0a04e;
	logic [7:0] exq[$];  // Bytes the device should hold
	infrared_frame_controller #(.BIT_CYC_2400(20)) DUT (.ref_clk, .rst_n,
		.csN, .rdN, .wrN, .addr, .dataIn, .dataOut, .dataOe, .dreq, .dackN,
		.tcN, .intReq, .linkMode, .sendMode, .recvMode, .txByte, .txValid,
		.txReady, .rxByte, .rxValid, .rxFlag);
	ir_coder_model coder (.ref_clk, .txValid, .txByte, .txReady,
		.rxByte, .rxValid, .rxFlag);
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// Hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic chkByte(input string s, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", s, e, g);
			err_count++;
		end
	endtask : chkByte
	task automatic chkBit(input string s, input logic e, input logic g);
		chkByte(s, {7'h0, e}, {7'h0, g});
	endtask : chkBit
	// One host or DMA access; strobe held three cycles
	task automatic bus(input logic dma, input logic rd, input logic [3:0] a,
		input logic [7:0] d);
		@(posedge ref_clk);
		csN <= dma;
		dackN <= !dma;
		addr <= a;
		dataIn <= d;
		if (rd) rdN <= 1'b0;
		else wrN <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 q = dataOut;
		@(posedge ref_clk);
		{rdN, wrN, csN, dackN} <= 4'hf;
	endtask : bus
	task automatic rxPut(input logic [7:0] b);
		coder.put(b, 1'b0);
		exq.push_back(b);
	endtask : rxPut
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	initial
	begin
		{rdN, wrN, csN, dackN, tcN} = 5'h1f;
		addr = 4'h0;
		dataIn = 8'h00;
		rst_n = 1'b0;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		v = 8'($random(seed));
		bus(0, 0, `A_IEN, v);
		bus(0, 1, `A_IEN, 8'h00);
		chkByte("enable", v, q);
		bus(0, 0, 4'hd, 8'hff);
		bus(0, 1, 4'hd, 8'h00);
		chkByte("unmapped", 8'h00, q);
		bus(0, 0, `A_TFL_LO, 8'h03);
		bus(0, 1, `A_TFL_LO, 8'h00);
		chkByte("length", 8'h03, q);
		for (i = 0; i < 4; i++)
		begin
			bus(0, 0, `A_MODE, 8'(i));
			bus(0, 0, `A_LCTL1, 8'(i));
			chkByte("mode", 8'(i), {6'h0, linkMode});
			chkBit("recv", i[1], recvMode);
			chkBit("send", i == 1, sendMode);
		end
		$display("test registers done");
		bus(0, 0, `A_MODE, 8'h00);
		bus(0, 0, `A_IEN, 8'h20);
		bus(0, 0, `A_LCTL1, 8'h02);
		for (i = 0; i < 5; i++) rxPut(8'($random(seed)));
		bus(0, 1, `A_LSTAT, 8'h00);
		chkByte("fill", 8'(exq.size() << 2), q & 8'hfc);
		for (i = 0; i < 5; i++)
		begin
			bus(0, 1, `A_DATA, 8'h00);
			chkByte("rxdata", exq.pop_front(), q);
		end
		rxPut(8'($random(seed)));
		for (n = 0; n < 800 && intReq !== 1'b1; n++) @(posedge ref_clk);
		chkBit("tout_time", 1'b1, n >= 630 && n <= 660);
		bus(0, 1, `A_EVT, 8'h00);
		chkBit("tout_event", 1'b1, q[`E_TOUT]);
		bus(0, 1, `A_DATA, 8'h00);
		chkByte("rxdata", exq.pop_front(), q);
		$display("test receive done");
		bus(0, 0, `A_LCTL1, 8'h10);
		bus(0, 0, `A_MODE, 8'h01);
		bus(0, 0, `A_DMA, 8'h01);
		bus(0, 0, `A_THR, 8'h40);
		bus(0, 0, `A_LCTL1, 8'h02);
		coder.put(`FR_BOF, 1'b0);
		for (i = 0; i < 4; i++)
		begin
			repeat (2) @(posedge ref_clk);
			chkBit("dreq_low", 1'b0, dreq);
			rxPut(8'($random(seed)) & 8'h3f);
		end
		repeat (3) @(posedge ref_clk);
		chkBit("dreq_high", 1'b1, dreq);
		for (i = 0; i < 4; i++)
		begin
			bus(1, 1, `A_DATA, 8'h00);
			chkByte("dmadata", exq.pop_front(), q);
		end
		chkBit("dreq_drop", 1'b0, dreq);
		$display("test dma receive done");
		bus(0, 0, `A_LCTL1, 8'h10);
		bus(0, 0, `A_DMA, 8'h00);
		bus(0, 0, `A_TFL_HI, 8'h00);
		v = 8'($random(seed)) & 8'h3f;
		exq = '{`FR_BOF, v, `FR_ESC, 8'h5d, v ^ 8'h11};
		bus(0, 0, `A_DATA, v);
		bus(0, 0, `A_DATA, `FR_ESC);
		bus(0, 0, `A_DATA, v ^ 8'h11);
		bus(0, 0, `A_LCTL1, 8'h01);
		for (n = 0; n < 600 && coder.txSeen.size() < 8; n++) @(posedge ref_clk);
		repeat (40) @(posedge ref_clk);
		chkByte("txcount", 8'h08, 8'(coder.txSeen.size()));
		for (i = 0; i < 5; i++)
			chkByte("txframe", exq[i], coder.txSeen[i]);
		chkByte("txend", `FR_EOF, coder.txSeen[7]);
		bus(0, 0, `A_LCTL2, 8'h80);
		bus(0, 1, `A_TFL_LO, 8'h00);
		chkByte("livecount", 8'h03, q);
		bus(0, 0, `A_THR, 8'h04);
		bus(0, 0, `A_DMA, 8'h01);
		chkBit("tx_dreq", 1'b1, dreq);
		$display("test transmit done");
		report_and_stop();
	end
endmodule : test_infrared_frame_controller
bind infrared_frame_controller ir_frame_assertions chk (.ref_clk, .rst_n,
	.csN, .rdN, .wrN, .addr, .dataIn, .dataOut, .dataOe, .dreq, .dackN,
	.txValid, .txReady, .txByte, .sendMode, .recvMode, .linkMode);
`default_nettype wire
